// file: rtl/dpc_defs.vh
// Constants for the strobe preamble/postamble controller.
// Assumes inclusion by bare name from rtl/ design files and the testbench.
`ifndef DPC_DEFS_VH
`define DPC_DEFS_VH

// ***********************************************
// APB register byte offsets
// ***********************************************
`define DPC_OFS_CFG 8'h00
`define DPC_OFS_CMD 8'h04
`define DPC_OFS_WDLO 8'h08
`define DPC_OFS_WDHI 8'h0C
`define DPC_OFS_STAT 8'h10

// ***********************************************
// Configuration register fields
// ***********************************************
`define DPC_CFG_WPRE2 0
`define DPC_CFG_RPRE2 1
`define DPC_CFG_CRC 2
`define DPC_CFG_FAST 3
`define DPC_CFG_MPR 4
`define DPC_CFG_ALT 5
`define DPC_CFG_WRSTD 6
`define DPC_CFG_CWL_LO 8
`define DPC_CFG_CWL_HI 12
`define DPC_CFG_CWP_LO 16
`define DPC_CFG_CWP_HI 18
`define DPC_CFG_CW2_LO 20
`define DPC_CFG_CW2_HI 22
`define DPC_CFG_WR_LO 24
`define DPC_CFG_WR_HI 26
`define DPC_CFG_RST 32'h0000_0900

// ***********************************************
// Command register fields and opcodes
// ***********************************************
`define DPC_CMD_OP_LO 0
`define DPC_CMD_OP_HI 1
`define DPC_CMD_MR_LO 4
`define DPC_CMD_MR_HI 6
`define DPC_CMD_VAL_LO 8
`define DPC_CMD_VAL_HI 24
`define DPC_CMD_BA_LO 28
`define DPC_CMD_BA_HI 29
`define DPC_CMD_BG_LO 30
`define DPC_CMD_BG_HI 31
`define DPC_OP_MRS 2'h0
`define DPC_OP_WR 2'h1
`define DPC_OP_RD 2'h2

// ***********************************************
// Status register fields
// ***********************************************
`define DPC_ST_BUSY 0
`define DPC_ST_TRAIN 1
`define DPC_ST_PREERR 2
`define DPC_ST_TRNERR 3
`define DPC_ST_STALL 4
`define DPC_ST_TMO 5
`define DPC_ST_MEAS_LO 8
`define DPC_ST_MEAS_HI 12
`define DPC_ST_BYTE_LO 16
`define DPC_ST_BYTE_HI 23

// ***********************************************
// Mode register numbers and overlaid bits
// ***********************************************
`define DPC_MR0 3'h0
`define DPC_MR2 3'h2
`define DPC_MR4 3'h4
`define DPC_MR4_WPRE 12
`define DPC_MR4_RPRE 11
`define DPC_MR4_TRAIN 10
`define DPC_MR2_CWL_LO 3
`define DPC_MR2_CWL_HI 5
`define DPC_MR0_WR_LO 9
`define DPC_MR0_WR_HI 11

// ***********************************************
// Command pin codes {ras_n, cas_n, we_n}
// ***********************************************
`define DPC_PIN_MRS 3'b000
`define DPC_PIN_WR 3'b100
`define DPC_PIN_RD 3'b101

// ***********************************************
// Timing in command clocks / strobe beats
// ***********************************************
`define DPC_CCD_MIN 4'h4
`define DPC_CCD_BAD5 4'h5
`define DPC_CCD_BAD6 4'h6
`define DPC_GAP_MAX 4'hF
`define DPC_CWL_PRE2_ADD 5'h02
`define DPC_BEATS 7'h08
`define DPC_MRS_WAIT_CK 8'h18
`define DPC_SDO_CK 8'h20
`define DPC_RD_TMO 8'hFF

`endif

// file: rtl/dpc_sync2.v
// Two-flop synchroniser for a bus of independent pin levels.
// Assumes each bit is a slow level or is re-sampled by the reader.
`timescale 1ns/1ps
module dpc_sync2 #(
  parameter W = 1
) (
  input wire pclk,
  input wire presetn,
  input wire [W-1:0] d_i,
  output wire [W-1:0] q_o
);
  reg [W-1:0] s1_r;
  reg [W-1:0] s2_r;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_r <= {W{1'b0}};
      s2_r <= {W{1'b0}};
    end else begin
      s1_r <= d_i;
      s2_r <= s1_r;
    end
  end

  assign q_o = s2_r;
endmodule

// file: rtl/dpc_ctrl.v
// Host controller for DRAM strobe preamble/postamble modes, APB slave.
// Assumes one DRAM on the pins; command clock is pclk divided by two.
// Function
// RQ1 - Write and read preamble lengths, one or two clocks, chosen independently.
// RQ2 - Two-clock preamble only allowed when the fast-rate bit is set.
// RQ3 - Two-clock read, or write without CRC: never space columns by 5.
// RQ4 - Two-clock write with CRC: never space column commands by 6 clocks.
// RQ5 - Mode register 4 bit 12 selects write preamble length.
// RQ6 - Two-clock write preamble raises primary write latency; alternate unchanged.
// RQ7 - Write latency code placed in mode register 2 bits 5:3.
// RQ8 - Optional extra clock of write recovery in two-clock write mode.
// RQ9 - Mode register 4 bit 11 selects read preamble length.
// RQ10 - Read preamble training only allowed in multipurpose register mode.
// RQ11 - Training entered and left by mode register 4 bit 10.
// RQ12 - Device drives strobes valid within settle time; host waits for it.
// RQ13 - Device holds strobe low until page 0 register read, then toggles.
// RQ14 - Write postamble is half a clock for either preamble length.
// RQ15 - Device read postamble is half a clock for either preamble.
// RQ16 - Strobe driven low one or two clocks before first data edge.
//
// Implementation choices: the APB slave port and the placing of the registers.
`timescale 1ns/1ps
`include "dpc_defs.vh"
module dpc_ctrl #(
  parameter MRS_WAIT_CK = `DPC_MRS_WAIT_CK,
  parameter SDO_CK = `DPC_SDO_CK,
  parameter RD_TMO = `DPC_RD_TMO
) (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output wire pslverr,
  output wire ck_t_o,
  output wire ck_c_o,
  output reg cs_n_o,
  output wire act_n_o,
  output reg ras_n_o,
  output reg cas_n_o,
  output reg we_n_o,
  output reg [1:0] bg_o,
  output reg [1:0] ba_o,
  output reg [16:0] addr_o,
  output reg [7:0] dq_o,
  output reg dq_oe,
  input wire [7:0] dq_i,
  output reg dqs_t_o,
  output reg dqs_c_o,
  output reg dqs_oe,
  input wire dqs_t_i,
  input wire dqs_c_i
);
  // ***********************************************
  // States
  // ***********************************************
  localparam S_IDLE = 3'h0;
  localparam S_MRS = 3'h1;
  localparam S_COL = 3'h2;
  localparam S_WAIT = 3'h3;
  localparam S_WR = 3'h4;
  localparam S_RD = 3'h5;

  reg [2:0] state_r;
  reg ck_r;
  reg [31:0] cfg_r;
  reg [31:0] cmd_r;
  reg [31:0] wdlo_r;
  reg [31:0] wdhi_r;
  reg [5:0] st_r;
  reg [4:0] meas_r;
  reg [7:0] rbyte_r;
  reg [3:0] gap_r;
  reg [7:0] wait_r;
  reg [6:0] wcnt_r;
  reg [7:0] rcnt_r;
  reg [4:0] lowrun_r;
  reg dqs_prev_r;
  reg train_r;
  wire [1:0] dqs_s;
  wire [7:0] dq_s;

  dpc_sync2 #(.W(2)) u_sync_dqs (
    .pclk(pclk),
    .presetn(presetn),
    .d_i({dqs_c_i, dqs_t_i}),
    .q_o(dqs_s)
  );

  dpc_sync2 #(.W(8)) u_sync_dq (
    .pclk(pclk),
    .presetn(presetn),
    .d_i(dq_i),
    .q_o(dq_s)
  );

  // ***********************************************
  // Mode decode
  // ***********************************************
  wire fast = cfg_r[`DPC_CFG_FAST];
  wire wpre2 = cfg_r[`DPC_CFG_WPRE2] & fast; // see RQ1 see RQ2
  wire rpre2 = cfg_r[`DPC_CFG_RPRE2] & fast; // see RQ1 see RQ2
  wire crc_en = cfg_r[`DPC_CFG_CRC];
  wire prim_up = wpre2 & ~cfg_r[`DPC_CFG_ALT];
  // Primary latency value grows in two-clock mode; alternate does not
  wire [4:0] cwl_eff = cfg_r[`DPC_CFG_CWL_HI:`DPC_CFG_CWL_LO] +
                       (prim_up ? `DPC_CWL_PRE2_ADD : 5'h00); // see RQ6
  wire [2:0] cwl_code = prim_up ? cfg_r[`DPC_CFG_CW2_HI:`DPC_CFG_CW2_LO] :
                        cfg_r[`DPC_CFG_CWP_HI:`DPC_CFG_CWP_LO];
  wire [2:0] wr_code = cfg_r[`DPC_CFG_WR_HI:`DPC_CFG_WR_LO] +
                       {2'b00, wpre2 & cfg_r[`DPC_CFG_WRSTD]}; // see RQ8
  wire bad5 = rpre2 | (wpre2 & ~crc_en); // see RQ3
  wire bad6 = wpre2 & crc_en; // see RQ4
  wire cas_ok = (gap_r >= `DPC_CCD_MIN) &&
                !(bad5 && gap_r == `DPC_CCD_BAD5) &&
                !(bad6 && gap_r == `DPC_CCD_BAD6);

  wire [1:0] op = cmd_r[`DPC_CMD_OP_HI:`DPC_CMD_OP_LO];
  wire [2:0] mr = cmd_r[`DPC_CMD_MR_HI:`DPC_CMD_MR_LO];
  wire [16:0] mval = cmd_r[`DPC_CMD_VAL_HI:`DPC_CMD_VAL_LO];
  wire train_req = mval[`DPC_MR4_TRAIN];
  wire train_ok = cfg_r[`DPC_CFG_MPR]; // see RQ10
  reg [16:0] mr_word;

  always @* begin
    mr_word = mval;
    if (mr == `DPC_MR4) begin
      mr_word[`DPC_MR4_WPRE] = wpre2; // see RQ5
      mr_word[`DPC_MR4_RPRE] = rpre2; // see RQ9
      mr_word[`DPC_MR4_TRAIN] = train_req & train_ok; // see RQ11
    end else if (mr == `DPC_MR2) begin
      mr_word[`DPC_MR2_CWL_HI:`DPC_MR2_CWL_LO] = cwl_code; // see RQ7
    end else if (mr == `DPC_MR0) begin
      mr_word[`DPC_MR0_WR_HI:`DPC_MR0_WR_LO] = wr_code; // see RQ8
    end
  end

  // ***********************************************
  // APB slave, zero wait states
  // ***********************************************
  wire busy = (state_r != S_IDLE);
  wire acc = psel & penable;
  wire wr_acc = acc & pwrite;
  wire hit = (paddr == `DPC_OFS_CFG) || (paddr == `DPC_OFS_CMD) ||
             (paddr == `DPC_OFS_WDLO) || (paddr == `DPC_OFS_WDHI) ||
             (paddr == `DPC_OFS_STAT);
  // A command posted while busy is dropped and flagged as an error
  wire cmd_wr = wr_acc & (paddr == `DPC_OFS_CMD);
  assign pready = 1'b1;
  assign pslverr = acc & (~hit | (cmd_wr & busy));

  always @* begin
    case (paddr)
      `DPC_OFS_CFG: prdata = cfg_r;
      `DPC_OFS_CMD: prdata = cmd_r;
      `DPC_OFS_WDLO: prdata = wdlo_r;
      `DPC_OFS_WDHI: prdata = wdhi_r;
      `DPC_OFS_STAT: prdata = {8'h00, rbyte_r, 3'b000, meas_r, 2'b00, st_r[5:2],
                               train_r, busy};
      default: prdata = 32'h0000_0000;
    endcase
  end

  // ***********************************************
  // Command clock and sequencer
  // ***********************************************
  // Pins change when ck is high so they are stable across the next rise
  wire ce = ck_r;
  assign ck_t_o = ck_r;
  assign ck_c_o = ~ck_r;
  assign act_n_o = 1'b1;

  wire [6:0] d0 = {cwl_eff, 1'b0} + 7'h01;
  wire [6:0] pre_st = d0 - (wpre2 ? 7'h04 : 7'h02); // see RQ16
  wire [6:0] beat = wcnt_r - d0;
  wire in_pre = (wcnt_r >= pre_st) && (wcnt_r < d0);
  wire in_dat = (wcnt_r >= d0) && (wcnt_r < d0 + `DPC_BEATS);
  wire in_post = (wcnt_r == d0 + `DPC_BEATS);
  wire [63:0] wdat = {wdhi_r, wdlo_r};
  wire rise = dqs_s[0] & ~dqs_prev_r;
  reg [5:0] set_v;
  reg [5:0] clr_v;

  always @* begin
    set_v = 6'h00;
    clr_v = 6'h00;
    if (wr_acc && paddr == `DPC_OFS_STAT)
      clr_v = pwdata[5:0];
    if (wr_acc && paddr == `DPC_OFS_CFG && !pwdata[`DPC_CFG_FAST] &&
        (pwdata[`DPC_CFG_WPRE2] | pwdata[`DPC_CFG_RPRE2]))
      set_v[`DPC_ST_PREERR] = 1'b1; // see RQ2
    if (state_r == S_MRS && ce && mr == `DPC_MR4 && train_req && !train_ok)
      set_v[`DPC_ST_TRNERR] = 1'b1; // see RQ10
    if (state_r == S_COL && ce && !cas_ok && gap_r >= `DPC_CCD_MIN)
      set_v[`DPC_ST_STALL] = 1'b1;
    if (state_r == S_RD && !rise && rcnt_r == RD_TMO[7:0])
      set_v[`DPC_ST_TMO] = 1'b1;
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= S_IDLE;
      ck_r <= 1'b0;
      cfg_r <= `DPC_CFG_RST;
      cmd_r <= 32'h0000_0000;
      wdlo_r <= 32'h0000_0000;
      wdhi_r <= 32'h0000_0000;
      st_r <= 6'h00;
      meas_r <= 5'h00;
      rbyte_r <= 8'h00;
      gap_r <= `DPC_GAP_MAX;
      wait_r <= 8'h00;
      wcnt_r <= 7'h00;
      rcnt_r <= 8'h00;
      lowrun_r <= 5'h00;
      dqs_prev_r <= 1'b0;
      train_r <= 1'b0;
      cs_n_o <= 1'b1;
      ras_n_o <= 1'b1;
      cas_n_o <= 1'b1;
      we_n_o <= 1'b1;
      bg_o <= 2'h0;
      ba_o <= 2'h0;
      addr_o <= 17'h00000;
      dq_o <= 8'hFF;
      dq_oe <= 1'b0;
      dqs_t_o <= 1'b0;
      dqs_c_o <= 1'b1;
      dqs_oe <= 1'b0;
    end else begin
      ck_r <= ~ck_r;
      dqs_prev_r <= dqs_s[0];
      st_r <= (st_r & ~clr_v) | set_v;
      if (wr_acc && paddr == `DPC_OFS_CFG)
        cfg_r <= pwdata;
      if (wr_acc && paddr == `DPC_OFS_WDLO)
        wdlo_r <= pwdata;
      if (wr_acc && paddr == `DPC_OFS_WDHI)
        wdhi_r <= pwdata;
      if (ce) begin
        cs_n_o <= 1'b1;
        if (gap_r != `DPC_GAP_MAX)
          gap_r <= gap_r + 4'h1;
      end
      case (state_r)
        S_IDLE: begin
          if (cmd_wr) begin
            cmd_r <= pwdata;
            state_r <= (pwdata[`DPC_CMD_OP_HI:`DPC_CMD_OP_LO] == `DPC_OP_MRS) ?
                       S_MRS : S_COL;
          end
        end
        S_MRS: begin
          if (ce) begin
            cs_n_o <= 1'b0;
            {ras_n_o, cas_n_o, we_n_o} <= `DPC_PIN_MRS;
            bg_o <= {1'b0, mr[2]};
            ba_o <= mr[1:0];
            addr_o <= mr_word;
            if (mr == `DPC_MR4) begin
              train_r <= train_req & train_ok; // see RQ11
              // Strobes need settle time after training entry
              wait_r <= (train_req & train_ok) ? SDO_CK[7:0] : MRS_WAIT_CK[7:0]; // see RQ12
            end else begin
              wait_r <= MRS_WAIT_CK[7:0];
            end
            state_r <= S_WAIT;
          end
        end
        S_WAIT: begin
          if (ce) begin
            if (wait_r == 8'h00)
              state_r <= S_IDLE;
            else
              wait_r <= wait_r - 8'h01;
          end
        end
        S_COL: begin
          if (ce && cas_ok) begin
            cs_n_o <= 1'b0;
            {ras_n_o, cas_n_o, we_n_o} <= (op == `DPC_OP_WR) ? `DPC_PIN_WR :
                                          `DPC_PIN_RD;
            bg_o <= cmd_r[`DPC_CMD_BG_HI:`DPC_CMD_BG_LO];
            ba_o <= cmd_r[`DPC_CMD_BA_HI:`DPC_CMD_BA_LO];
            addr_o <= mval;
            gap_r <= 4'h1; // see RQ3 see RQ4
            wcnt_r <= 7'h00;
            rcnt_r <= 8'h00;
            lowrun_r <= 5'h00;
            state_r <= (op == `DPC_OP_WR) ? S_WR : S_RD;
          end
        end
        S_WR: begin
          wcnt_r <= wcnt_r + 7'h01;
          dqs_oe <= in_pre | in_dat | in_post;
          dq_oe <= in_dat;
          dq_o <= in_dat ? wdat[{beat[2:0], 3'b000} +: 8] : 8'hFF;
          if (in_dat) begin
            dqs_t_o <= ~beat[0];
            dqs_c_o <= beat[0];
          end else begin
            // Preamble and half-clock postamble both hold the strobe low
            dqs_t_o <= 1'b0; // see RQ14 see RQ16
            dqs_c_o <= 1'b1;
          end
          // One edge past the postamble so the strobe enable drops again
          if (wcnt_r == d0 + `DPC_BEATS + 7'h01)
            state_r <= S_IDLE;
        end
        S_RD: begin
          rcnt_r <= rcnt_r + 8'h01;
          // Low time before the first rise reports the received preamble
          if (!dqs_s[0] && dqs_s[1] && lowrun_r != 5'h1F)
            lowrun_r <= lowrun_r + 5'h01; // see RQ13
          if (rise) begin
            meas_r <= lowrun_r;
            rbyte_r <= dq_s;
            state_r <= S_IDLE;
          end else if (rcnt_r == RD_TMO[7:0]) begin
            state_r <= S_IDLE;
          end
        end
        default: state_r <= S_IDLE;
      endcase
    end
  end
endmodule

// file: testbench/dpc_ctrl_properties.sv
// Checker for the strobe controller's pins and APB answers.
// Assumes binding to dpc_ctrl; it sees only the ports it watches.
`timescale 1ns/1ps
module dpc_ctrl_properties (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire [7:0] paddr,
  input wire pslverr,
  input wire ck_t_o,
  input wire cs_n_o,
  input wire ras_n_o,
  input wire cas_n_o,
  input wire we_n_o,
  input wire [1:0] bg_o,
  input wire [7:0] dq_o,
  input wire dq_oe,
  input wire dqs_t_o,
  input wire dqs_oe
);
  // ****************
  // Sequences and properties
  // ****************
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_cs_pulse;
    !cs_n_o ##1 cs_n_o;
  endsequence
  sequence s_pre_low;
    !dqs_t_o [*2];
  endsequence
  a_cs_two_cycles: assert property ($fell(cs_n_o) |=> s_cs_pulse)
    else $error("chip select low time wrong");
  a_cmd_hold: assert property ($fell(cs_n_o) |=> $stable({ras_n_o, cas_n_o, we_n_o}))
    else $error("command code moved under chip select");
  a_mrs_bank: assert property ($fell(cs_n_o) && {ras_n_o, cas_n_o, we_n_o} == 3'h0
    |-> bg_o[1] == 1'h0) else $error("mode write with upper bank group set");
  // Command clock must never stall, or the device loses its timing base
  a_ck_toggles: assert property (1'b1 |=> ck_t_o != $past(ck_t_o))
    else $error("command clock did not toggle");
  a_unmapped_err: assert property (psel && penable && paddr > 8'h10 |-> pslverr)
    else $error("unmapped access not refused");
  a_idle_dq: assert property (!dq_oe |-> dq_o == 8'hFF)
    else $error("data not high while idle");
  a_wpre_low: assert property ($rose(dqs_oe) |-> s_pre_low)
    else $error("write preamble shorter than one clock");
  a_wpost_half: assert property ($fell(dqs_oe) |-> !$past(dqs_t_o))
    else $error("write postamble not low");
endmodule
bind dpc_ctrl dpc_ctrl_properties chk_u (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .paddr(paddr), .pslverr(pslverr), .ck_t_o(ck_t_o), .cs_n_o(cs_n_o),
  .ras_n_o(ras_n_o), .cas_n_o(cas_n_o), .we_n_o(we_n_o), .bg_o(bg_o), .dq_o(dq_o),
  .dq_oe(dq_oe), .dqs_t_o(dqs_t_o), .dqs_oe(dqs_oe));

// file: testbench/dpc_dram_model.sv
// Behavioural DRAM: mode registers, read strobe and read data.
// Assumes the host pins change on pclk; read latency in command clocks.
`timescale 1ns/1ps
module dpc_dram_model #(
  parameter CL_CK = 16,
  parameter [7:0] BYTE0 = 8'hA5
) (
  input wire pclk,
  input wire presetn,
  input wire cs_n_o,
  input wire ras_n_o,
  input wire cas_n_o,
  input wire we_n_o,
  input wire [1:0] bg_o,
  input wire [1:0] ba_o,
  input wire [16:0] addr_o,
  output reg [7:0] dq_m,
  output reg dqs_t_m,
  output reg dqs_c_m
);
  // ****************
  // Command decode and read strobe
  // ****************
  reg [16:0] mr0_r, mr2_r, mr4_r;
  reg cs_q;
  integer ph, p, k;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cs_q <= 1'h1;
      ph <= -1;
      mr0_r <= 17'h0;
      mr2_r <= 17'h0;
      mr4_r <= 17'h0;
      dqs_t_m <= 1'h1;
      dqs_c_m <= 1'h0;
      dq_m <= 8'h00;
    end else begin
      cs_q <= cs_n_o;
      p = ph - 2 * CL_CK;
      k = p - (mr4_r[11] ? 4 : 2);
      if (!cs_n_o && cs_q && {ras_n_o, cas_n_o, we_n_o} == 3'h0) begin
        case ({bg_o[0], ba_o})
          3'h0: mr0_r <= addr_o;
          3'h2: mr2_r <= addr_o;
          3'h4: mr4_r <= addr_o;
          default: ;
        endcase
      end
      if (!cs_n_o && cs_q && {ras_n_o, cas_n_o, we_n_o} == 3'h5)
        ph <= 0;
      else if (ph >= 0 && k < 8)
        ph <= ph + 1;
      else
        ph <= -1;
      // Idle pair is complementary: strobe high outside training, held low during training
      if (ph < 0 || p < 0) begin
        dqs_t_m <= !mr4_r[10];
        dqs_c_m <= mr4_r[10];
        dq_m <= mr4_r[10] ? 8'hFF : ~dq_m;
      end else if (k < 0 || k == 8) begin
        dqs_t_m <= 1'h0;
        dqs_c_m <= 1'h1;
        dq_m <= 8'hFF;
      end else begin
        dqs_t_m <= ~k[0];
        dqs_c_m <= k[0];
        dq_m <= BYTE0 + k[7:0];
      end
    end
  end
endmodule

// file: testbench/dpc_ctrl_tb_top.sv
// Bench: APB tasks drive the controller against the DRAM model.
// Assumes rtl/ on the include path and the checker bound in.
`timescale 1ns/1ps
`include "dpc_defs.vh"
module dpc_ctrl_tb_top;
  reg pclk = 1'b0;
  reg presetn = 1'b0;
  reg psel = 1'b0;
  reg penable = 1'b0;
  reg pwrite = 1'b0;
  reg [7:0] paddr = 8'h00;
  reg [31:0] pwdata = 32'h0;
  reg [31:0] rd;
  reg err, seen = 1'b1, cs_q = 1'b1;
  reg [7:0] byte0;
  wire [31:0] prdata;
  wire pready, pslverr, ck_t_o, ck_c_o, cs_n_o, act_n_o, ras_n_o, cas_n_o, we_n_o;
  wire [1:0] bg_o, ba_o;
  wire [16:0] addr_o;
  wire [7:0] dq_o, dq_m;
  wire dq_oe, dqs_t_o, dqs_c_o, dqs_oe, dqs_t_m, dqs_c_m;
  integer n_mismatch = 0, comparisons = 0, cyc = 0, pre_cnt, oe_cnt, lat, w, r;
  integer lat_r [0:1];
  initial forever #2 pclk = ~pclk;
  dpc_ctrl #(.MRS_WAIT_CK(2), .SDO_CK(2), .RD_TMO(8'hFF)) dut_u (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .ck_t_o(ck_t_o),
    .ck_c_o(ck_c_o), .cs_n_o(cs_n_o), .act_n_o(act_n_o), .ras_n_o(ras_n_o),
    .cas_n_o(cas_n_o), .we_n_o(we_n_o), .bg_o(bg_o), .ba_o(ba_o), .addr_o(addr_o),
    .dq_o(dq_o), .dq_oe(dq_oe), .dq_i(dq_oe ? dq_o : dq_m), .dqs_t_o(dqs_t_o),
    .dqs_c_o(dqs_c_o), .dqs_oe(dqs_oe), .dqs_t_i(dqs_oe ? dqs_t_o : dqs_t_m),
    .dqs_c_i(dqs_oe ? dqs_c_o : dqs_c_m));
  dpc_dram_model dram_u (.pclk(pclk), .presetn(presetn), .cs_n_o(cs_n_o),
    .ras_n_o(ras_n_o), .cas_n_o(cas_n_o), .we_n_o(we_n_o), .bg_o(bg_o), .ba_o(ba_o),
    .addr_o(addr_o), .dq_m(dq_m), .dqs_t_m(dqs_t_m), .dqs_c_m(dqs_c_m));
  // ****************
  // Tasks
  // ****************
  task end_of_test;
    begin
      if (n_mismatch == 0 && comparisons > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
    end
  endtask
  task chk(input string name, input [31:0] exp, input [31:0] got);
    begin
      comparisons = comparisons + 1;
      if (got !== exp) begin
        n_mismatch = n_mismatch + 1;
        $display("MISMATCH %s expected %h seen %h", name, exp, got);
      end
    end
  endtask
  task apb(input wr, input [7:0] a, input [31:0] d);
    begin
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
    end
  endtask
  task st;
    apb(1'b0, `DPC_OFS_STAT, 32'h0);
  endtask
  task cfg(input [31:0] d);
    apb(1'b1, `DPC_OFS_CFG, d);
  endtask
  task cmd(input [1:0] op, input [2:0] mr, input [16:0] v);
    begin
      st;
      while (rd[`DPC_ST_BUSY] !== 1'b0) st;
      apb(1'b1, `DPC_OFS_CMD, {7'h00, v, 1'h0, mr, 2'h0, op});
      st;
      while (rd[`DPC_ST_BUSY] !== 1'b0) st;
    end
  endtask
  // ****************
  // Write strobe monitor and timeout
  // ****************
  always @(posedge pclk) begin
    cs_q <= cs_n_o;
    cyc = cyc + 1;
    if (!cs_n_o && cs_q && {ras_n_o, cas_n_o, we_n_o} == `DPC_PIN_WR) begin
      lat = 0;
      seen = 1'b0;
      pre_cnt = 0;
      oe_cnt = 0;
    end else if (!seen) lat = lat + 1;
    if (dqs_oe) begin
      oe_cnt = oe_cnt + 1;
      if (!seen && !dqs_t_o) pre_cnt = pre_cnt + 1;
      if (!seen && dqs_t_o) byte0 = dq_o;
      if (dqs_t_o) seen = 1'b1;
    end
    // Ceiling far above the several hundred cycles the sequence needs
    if (cyc == 60000) begin
      n_mismatch = n_mismatch + 1;
      end_of_test;
    end
  end
  // ****************
  // Main sequence
  // ****************
  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, `DPC_OFS_CFG, 32'h0);
    chk("cfg reset", `DPC_CFG_RST, rd);
    apb(1'b0, 8'h20, 32'h0);
    chk("unmapped err", 32'h1, {31'h0, err});
    apb(1'b1, `DPC_OFS_WDLO, 32'h44332211);
    for (w = 0; w < 2; w = w + 1) begin
      for (r = 0; r < 2; r = r + 1) begin
        cfg(32'h0265_0C48 | w | (r << 1));
        cmd(`DPC_OP_MRS, `DPC_MR4, 17'h0);
        chk("mr4 wpre", w, dram_u.mr4_r[`DPC_MR4_WPRE]);
        chk("mr4 rpre", r, dram_u.mr4_r[`DPC_MR4_RPRE]);
        cmd(`DPC_OP_MRS, `DPC_MR2, 17'h0);
        chk("mr2 cwl", w ? 6 : 5, dram_u.mr2_r[5:3]);
        cmd(`DPC_OP_MRS, `DPC_MR0, 17'h0);
        chk("mr0 wr", 2 + w, dram_u.mr0_r[11:9]);
        cmd(`DPC_OP_WR, 3'h0, 17'h0);
        chk("wr preamble", 2 + 2 * w, pre_cnt);
        chk("wr strobe span", 11 + 2 * w, oe_cnt);
        chk("wr byte0", 8'h11, byte0);
        chk("wr latency", 26 + 4 * w, lat);
        lat_r[w] = lat;
        cmd(`DPC_OP_RD, 3'h0, 17'h0);
        chk("rd preamble", 2 + 2 * r, rd[12:8]);
        chk("rd byte", 8'hA5, rd[23:16]);
      end
    end
    chk("lat gap", 4, lat_r[1] - lat_r[0]);
    cfg(32'h0265_0C29);
    cmd(`DPC_OP_MRS, `DPC_MR2, 17'h0);
    chk("mr2 alt", 5, dram_u.mr2_r[5:3]);
    apb(1'b1, `DPC_OFS_CMD, {30'h0, `DPC_OP_WR});
    apb(1'b1, `DPC_OFS_CMD, {30'h0, `DPC_OP_WR});
    chk("busy refusal", 1, err);
    cmd(`DPC_OP_RD, 3'h0, 17'h0);
    chk("alt latency", 26, lat);
    cfg(32'h0265_0C03);
    cmd(`DPC_OP_MRS, `DPC_MR4, 17'h0);
    chk("slow wpre", 0, dram_u.mr4_r[`DPC_MR4_WPRE]);
    chk("pre err", 1, rd[`DPC_ST_PREERR]);
    cfg(32'h0265_0C08);
    apb(1'b1, `DPC_OFS_STAT, 32'h3C);
    cmd(`DPC_OP_MRS, `DPC_MR4, 17'h0400);
    chk("train gated", 0, dram_u.mr4_r[`DPC_MR4_TRAIN]);
    chk("train err", 32'h8, rd & 32'hC);
    cfg(32'h0265_0C18);
    cmd(`DPC_OP_MRS, `DPC_MR4, 17'h0400);
    chk("train on", 1, dram_u.mr4_r[`DPC_MR4_TRAIN]);
    chk("train active", 1, rd[`DPC_ST_TRAIN]);
    cmd(`DPC_OP_RD, 3'h0, 17'h0);
    chk("train count", 31, rd[12:8]);
    cmd(`DPC_OP_MRS, `DPC_MR4, 17'h0);
    chk("train off", 0, dram_u.mr4_r[`DPC_MR4_TRAIN]);
    end_of_test;
  end
endmodule
